/* File: hdl/dcss_pkg.sv */
// constants for the door command and speed-select block
package dcss_pkg;
   // register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] PROF_OFS = 8'h04;
   localparam logic [7:0] WEIGHT_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;
   // field positions
   localparam int GLASS_LSB = 0;
   localparam int IFACE_LSB = 4;
   localparam int CLOSED_INV_BIT = 8;
   localparam int OPEN_INV_BIT = 9;
   localparam int OSEL_LSB = 0;
   localparam int CSEL_LSB = 4;
   localparam int PRESET_BIT = 31;
   localparam int CAP_LSB = 16;
   // reset values and codes
   localparam logic [1:0] GLASS_NONE = 2'h0;
   localparam logic [1:0] GLASS_FITTED = 2'h1;
   localparam logic [2:0] IFACE_HI_NUDGE = 3'h0;
   localparam logic [2:0] IFACE_LO_ENABLE = 3'h1;
   localparam logic [2:0] IFACE_HI_ENABLE = 3'h2;
   localparam logic [2:0] IFACE_LO_NUDGE = 3'h3;
   localparam logic [2:0] IFACE_CANOPEN = 3'h4;
   localparam logic [2:0] PROF_DEFAULT = 3'h2;
   localparam logic [2:0] PROF_MAX = 3'h4;
   // speeds in mm/s
   localparam logic [9:0] GLASS_CAP_MMS = 10'h1f4;
   localparam logic [9:0] SPEED_TOP = 10'h3ff;
   // v^2 * kg limit, (mm/s)^2 kg, for 10 J
   localparam logic [31:0] ENERGY_LIMIT = 32'h01312d00;
   // profile tables, entry 0 is the 50 % profile
   localparam logic [4:0][9:0] OPEN_START =
      {10'h037, 10'h037, 10'h032, 10'h02d, 10'h02d};
   localparam logic [4:0][9:0] OPEN_HIGH =
      {10'h2bc, 10'h258, 10'h1f4, 10'h190, 10'h12c};
   localparam logic [4:0][9:0] OPEN_FINAL =
      {10'h028, 10'h028, 10'h023, 10'h01e, 10'h01e};
   localparam logic [4:0][9:0] CLOSE_START =
      {10'h02d, 10'h02d, 10'h028, 10'h023, 10'h023};
   localparam logic [4:0][9:0] CLOSE_HIGH =
      {10'h1c2, 10'h190, 10'h15e, 10'h12c, 10'h0fa};
   localparam logic [4:0][9:0] CLOSE_FINAL =
      {10'h028, 10'h028, 10'h023, 10'h01e, 10'h01e};
   typedef enum logic [1:0] {
      DCSS_IDLE,
      DCSS_OPENING,
      DCSS_CLOSING
   } dcss_motion_t;
endpackage : dcss_pkg

/* File: hdl/dcss_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module dcss_sync #(
   parameter int W = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // three flops; first one feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // accept a bit once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end
endmodule : dcss_sync
`default_nettype wire

/* File: hdl/dcss_profile_lut.sv */
// preset profile lookup for one direction of travel
`timescale 1ns/1ns
`default_nettype none
module dcss_profile_lut #(
   parameter bit IS_CLOSE = 1'b0
) (
   input wire logic [2:0] sel,
   output logic [9:0] start_mms,
   output logic [9:0] high_mms,
   output logic [9:0] final_mms
);
   logic [2:0] idx;

   // out-of-range codes fall back to the default profile
   always_comb begin
      idx = (sel > dcss_pkg::PROF_MAX) ? dcss_pkg::PROF_DEFAULT : sel;
      if (IS_CLOSE) begin
         start_mms = dcss_pkg::CLOSE_START[idx];
         high_mms = dcss_pkg::CLOSE_HIGH[idx];
         final_mms = dcss_pkg::CLOSE_FINAL[idx];
      end else begin
         start_mms = dcss_pkg::OPEN_START[idx];
         high_mms = dcss_pkg::OPEN_HIGH[idx];
         final_mms = dcss_pkg::OPEN_FINAL[idx];
      end
   end
endmodule : dcss_profile_lut
`default_nettype wire

/* File: hdl/dcss_top.sv */
// door command decode, relay logic and speed selection
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
//
// Summary of operation
// - glass setting resets to 00; no glass speed cap then.
// - glass setting 01 caps every door speed at 500 mm/s.
// - mode 00: inputs active high; reduced input forces priority slow close.
// - mode 01: inputs active low; reduced input only enables slow motion.
// - mode 02: inputs active high; reduced input only enables slow motion.
// - mode 03: inputs active low; reduced input forces priority slow close.
// - enable modes: open or close plus reduced input moves slowly.
// - enable modes: reduced input alone starts no movement.
// - mode 04: discrete inputs ignored, commands come from CANopen side.
// - mode 04: only auxiliary relay signals, switching at closed position.
// - door relays rest closed, open only at their final position.
// - each door relay contact logic inverts by its own bit.
// - opening and closing selectors pick one of 5 profiles, default 02.
// - opening profile speeds follow the preset opening table.
// - closing profile speeds follow the preset closing table.
// - closing high speed kept within 10 J for the panel weight.
// - profile reset trigger restores both selectors to default.
module dcss_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic open_command,
   input wire logic close_command,
   input wire logic reduced_speed_command,
   input wire logic can_open_req,
   input wire logic can_close_req,
   input wire logic can_reduced_req,
   input wire logic door_at_open_pos,
   input wire logic door_at_closed_pos,
   output logic motion_open,
   output logic motion_close,
   output logic motion_reduced,
   output logic [9:0] speed_start,
   output logic [9:0] speed_high,
   output logic [9:0] speed_final,
   output logic door_closed_relay,
   output logic door_open_relay,
   output logic auxiliary_closed_relay
);
   // configuration registers
   logic [1:0] glass_q;
   logic [2:0] iface_q, osel_q, csel_q;
   logic closed_inv_q, open_inv_q;
   logic [8:0] weight_q;
   logic [9:0] ke_cap_q;
   // bus handshake
   logic access, wr_en, rd_en, addr_ok;
   logic [31:0] rd_word;
   // synchronised pins
   logic [2:0] pins_q;
   // decoded requests, active high
   logic pin_open, pin_close, pin_reduced;
   logic req_open, req_close, req_reduced;
   logic nudge_mode, low_active;
   dcss_pkg::dcss_motion_t motion_d;
   logic reduced_d;
   // profile lookups
   logic [9:0] o_start, o_high, o_final;
   logic [9:0] c_start, c_high, c_final;
   logic [9:0] start_d, high_d, final_d;
   logic [9:0] ceil_mms, cap_up;

   // kinetic term v^2 * kg
   function automatic logic [31:0] energy(
      input logic [9:0] v,
      input logic [8:0] w
   );
      logic [31:0] vv;
      vv = 32'(v) * 32'(v);
      return vv * 32'(w);
   endfunction : energy

   // lower of two speeds
   function automatic logic [9:0] vmin(
      input logic [9:0] a,
      input logic [9:0] b
   );
      return (a < b) ? a : b;
   endfunction : vmin

   // legal profile code
   function automatic logic prof_ok(input logic [2:0] c);
      return c <= dcss_pkg::PROF_MAX;
   endfunction : prof_ok

   // apb decode
   assign access = psel & penable & ~pready;
   assign wr_en = access & pwrite;
   assign rd_en = access & ~pwrite;
   assign addr_ok = (paddr == dcss_pkg::CFG_OFS) |
                    (paddr == dcss_pkg::PROF_OFS) |
                    (paddr == dcss_pkg::WEIGHT_OFS) |
                    (paddr == dcss_pkg::STAT_OFS);

   // one wait state then a single-cycle ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= access & ~addr_ok;
      end
   end

   // read mux
   always_comb begin
      rd_word = '0;
      unique case (paddr)
         dcss_pkg::CFG_OFS: begin
            rd_word[dcss_pkg::GLASS_LSB +: 2] = glass_q;
            rd_word[dcss_pkg::IFACE_LSB +: 3] = iface_q;
            rd_word[dcss_pkg::CLOSED_INV_BIT] = closed_inv_q;
            rd_word[dcss_pkg::OPEN_INV_BIT] = open_inv_q;
         end
         dcss_pkg::PROF_OFS: begin
            rd_word[dcss_pkg::OSEL_LSB +: 3] = osel_q;
            rd_word[dcss_pkg::CSEL_LSB +: 3] = csel_q;
         end
         dcss_pkg::WEIGHT_OFS: rd_word[8:0] = weight_q;
         dcss_pkg::STAT_OFS: begin
            rd_word[0] = req_open;
            rd_word[1] = req_close;
            rd_word[2] = req_reduced;
            rd_word[3] = motion_open;
            rd_word[4] = motion_close;
            rd_word[5] = motion_reduced;
            rd_word[6] = door_closed_relay;
            rd_word[7] = door_open_relay;
            rd_word[8] = auxiliary_closed_relay;
            rd_word[dcss_pkg::CAP_LSB +: 10] = ke_cap_q;
         end
         default: rd_word = '0;
      endcase
   end

   // read data held from the ready cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_en) begin
         prdata <= rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         glass_q <= dcss_pkg::GLASS_NONE;
         iface_q <= dcss_pkg::IFACE_HI_NUDGE;
         closed_inv_q <= 1'b0;
         open_inv_q <= 1'b0;
      end else if (wr_en && paddr == dcss_pkg::CFG_OFS) begin
         glass_q <= pwdata[dcss_pkg::GLASS_LSB +: 2];
         closed_inv_q <= pwdata[dcss_pkg::CLOSED_INV_BIT];
         open_inv_q <= pwdata[dcss_pkg::OPEN_INV_BIT];
         // codes above 04 are kept out
         if (pwdata[dcss_pkg::IFACE_LSB +: 3] <= dcss_pkg::IFACE_CANOPEN) begin
            iface_q <= pwdata[dcss_pkg::IFACE_LSB +: 3];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osel_q <= dcss_pkg::PROF_DEFAULT;
         csel_q <= dcss_pkg::PROF_DEFAULT;
      end else if (wr_en && paddr == dcss_pkg::PROF_OFS) begin
         if (pwdata[dcss_pkg::PRESET_BIT]) begin
            osel_q <= dcss_pkg::PROF_DEFAULT;
            csel_q <= dcss_pkg::PROF_DEFAULT;
         end else begin
            if (prof_ok(pwdata[dcss_pkg::OSEL_LSB +: 3])) begin
               osel_q <= pwdata[dcss_pkg::OSEL_LSB +: 3];
            end
            if (prof_ok(pwdata[dcss_pkg::CSEL_LSB +: 3])) begin
               csel_q <= pwdata[dcss_pkg::CSEL_LSB +: 3];
            end
         end
      end
   end

   // panel weight, zero means no energy cap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         weight_q <= '0;
      end else if (wr_en && paddr == dcss_pkg::WEIGHT_OFS) begin
         weight_q <= pwdata[8:0];
      end
   end

   // energy cap walks one step per clock
   assign cap_up = ke_cap_q + 10'h001;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ke_cap_q <= dcss_pkg::SPEED_TOP;
      end else if (energy(ke_cap_q, weight_q) > dcss_pkg::ENERGY_LIMIT &&
                   ke_cap_q != '0) begin
         ke_cap_q <= ke_cap_q - 10'h001;
      end else if (ke_cap_q != dcss_pkg::SPEED_TOP &&
                   energy(cap_up, weight_q) <= dcss_pkg::ENERGY_LIMIT) begin
         ke_cap_q <= cap_up;
      end
   end

   dcss_sync #(
      .W(3)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in({reduced_speed_command, close_command, open_command}),
      .level_q(pins_q)
   );

   assign low_active = (iface_q == dcss_pkg::IFACE_LO_ENABLE) |
                       (iface_q == dcss_pkg::IFACE_LO_NUDGE);
   assign pin_open = pins_q[0] ^ low_active;
   assign pin_close = pins_q[1] ^ low_active;
   assign pin_reduced = pins_q[2] ^ low_active;
   assign nudge_mode = (iface_q == dcss_pkg::IFACE_HI_NUDGE) |
                       (iface_q == dcss_pkg::IFACE_LO_NUDGE);

   // canopen mode takes its own requests
   always_comb begin
      if (iface_q == dcss_pkg::IFACE_CANOPEN) begin
         req_open = can_open_req;
         req_close = can_close_req;
         req_reduced = can_reduced_req;
      end else begin
         req_open = pin_open;
         req_close = pin_close;
         req_reduced = pin_reduced;
      end
   end

   // motion decode; open beats close if both are asked
   always_comb begin
      motion_d = dcss_pkg::DCSS_IDLE;
      reduced_d = 1'b0;
      if (nudge_mode && req_reduced) begin
         motion_d = dcss_pkg::DCSS_CLOSING;
         reduced_d = 1'b1;
      end else if (req_open) begin
         motion_d = dcss_pkg::DCSS_OPENING;
         reduced_d = req_reduced;
      end else if (req_close) begin
         motion_d = dcss_pkg::DCSS_CLOSING;
         reduced_d = req_reduced;
      end
   end

   dcss_profile_lut #(
      .IS_CLOSE(1'b0)
   ) u_open_lut (
      .sel(osel_q),
      .start_mms(o_start),
      .high_mms(o_high),
      .final_mms(o_final)
   );

   dcss_profile_lut #(
      .IS_CLOSE(1'b1)
   ) u_close_lut (
      .sel(csel_q),
      .start_mms(c_start),
      .high_mms(c_high),
      .final_mms(c_final)
   );

   // speed reference for the chosen motion
   always_comb begin
      start_d = '0;
      high_d = '0;
      final_d = '0;
      ceil_mms = dcss_pkg::SPEED_TOP;
      if (glass_q == dcss_pkg::GLASS_FITTED) begin
         ceil_mms = dcss_pkg::GLASS_CAP_MMS;
      end
      unique case (motion_d)
         dcss_pkg::DCSS_OPENING: begin
            start_d = o_start;
            high_d = reduced_d ? o_start : o_high;
            final_d = o_final;
         end
         dcss_pkg::DCSS_CLOSING: begin
            ceil_mms = vmin(ceil_mms, ke_cap_q);
            start_d = c_start;
            high_d = reduced_d ? c_start : c_high;
            final_d = c_final;
         end
         dcss_pkg::DCSS_IDLE: start_d = '0;
      endcase
      start_d = vmin(start_d, ceil_mms);
      high_d = vmin(high_d, ceil_mms);
      final_d = vmin(final_d, ceil_mms);
   end

   // motion state and outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motion_open <= 1'b0;
         motion_close <= 1'b0;
         motion_reduced <= 1'b0;
      end else begin
         motion_open <= motion_d == dcss_pkg::DCSS_OPENING;
         motion_close <= motion_d == dcss_pkg::DCSS_CLOSING;
         motion_reduced <= reduced_d;
      end
   end

   // registered speed reference
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_start <= '0;
         speed_high <= '0;
         speed_final <= '0;
      end else begin
         speed_start <= start_d;
         speed_high <= high_d;
         speed_final <= final_d;
      end
   end

   // relays: 1 means contact closed, the unpowered state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         door_closed_relay <= 1'b1;
         door_open_relay <= 1'b1;
         auxiliary_closed_relay <= 1'b0;
      end else if (iface_q == dcss_pkg::IFACE_CANOPEN) begin
         door_closed_relay <= 1'b1;
         door_open_relay <= 1'b1;
         auxiliary_closed_relay <= door_at_closed_pos;
      end else begin
         door_closed_relay <= ~door_at_closed_pos ^ closed_inv_q;
         door_open_relay <= ~door_at_open_pos ^ open_inv_q;
         auxiliary_closed_relay <= 1'b0;
      end
   end
endmodule : dcss_top
`default_nettype wire

/* File: testbench/dcss_top_sva.sv */
// concurrent checks on the door command block ports
`timescale 1ns/1ns
`default_nettype none
module dcss_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic door_at_closed_pos,
   input wire logic motion_open,
   input wire logic motion_close,
   input wire logic motion_reduced,
   input wire logic [9:0] speed_start,
   input wire logic [9:0] speed_high,
   input wire logic auxiliary_closed_relay
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // bus answer one cycle into the access phase
   AST_READY_ONE_WAIT:
      assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle into access");
   AST_READY_PULSE:
      assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_ERR_UNMAPPED:
      assert property (psel && penable && !pready && paddr > 8'h0c
         |=> pready && pslverr)
      else $error("unmapped access not refused");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready)
      else $error("error without ready");
   // motion decode and speed relations
   AST_ONE_DIRECTION:
      assert property (!(motion_open && motion_close))
      else $error("open and close together");
   AST_SLOW_NEEDS_MOVE:
      assert property (motion_reduced |-> motion_open || motion_close)
      else $error("reduced flag without motion");
   AST_SLOW_SPEED:
      assert property (motion_reduced |-> speed_high == speed_start)
      else $error("reduced motion not at start speed");
   AST_CLOSE_LIMIT:
      assert property (motion_close |-> speed_high <= 10'h1c2)
      else $error("closing speed above fastest profile");
   AST_AUX_FOLLOWS:
      assert property (auxiliary_closed_relay |-> $past(door_at_closed_pos))
      else $error("aux relay without closed position");
   // main scenarios reached
   COV_NUDGE: cover property (motion_reduced && motion_close);
   COV_REFUSED: cover property (pslverr);
   COV_AUX: cover property (auxiliary_closed_relay);
endmodule : dcss_top_sva
bind dcss_top dcss_top_sva u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .door_at_closed_pos(door_at_closed_pos),
   .motion_open(motion_open), .motion_close(motion_close),
   .motion_reduced(motion_reduced), .speed_start(speed_start),
   .speed_high(speed_high),
   .auxiliary_closed_relay(auxiliary_closed_relay));
`default_nettype wire

/* File: testbench/dcss_mlc_model.sv */
// lift master controller model driving the discrete command pins
`timescale 1ns/1ns
`default_nettype none
module dcss_master_model (
   input wire logic pclk,
   input wire logic act_low,
   input wire logic [2:0] req,
   output logic open_command = 1'b0,
   output logic close_command = 1'b0,
   output logic reduced_speed_command = 1'b0
);
   always @(posedge pclk) begin
      open_command <= req[2] ^ act_low;
      close_command <= req[1] ^ act_low;
      reduced_speed_command <= req[0] ^ act_low;
   end
endmodule : dcss_master_model
`default_nettype wire

/* File: testbench/dcss_top_tb_top.sv */
// self-checking bench for the door command block
`timescale 1ns/1ns
`default_nettype none
module dcss_top_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, err;
   logic act_low = 1'b0;
   logic [2:0] req = 3'h0;
   logic [2:0] can = 3'h0;
   logic at_open = 1'b0;
   logic at_closed = 1'b0;
   logic pin_o, pin_c, pin_r, m_o, m_c, m_r, rly_c, rly_o, aux;
   logic [9:0] sp_s, sp_h, sp_f;
   int err_total = 0;
   int total_checks = 0;
   int oh[5] = '{300, 400, 500, 600, 700};
   int ch[5] = '{250, 300, 350, 400, 450};
   int os[5] = '{45, 45, 50, 55, 55};
   int cs[5] = '{35, 35, 40, 45, 45};
   int fs[5] = '{30, 30, 35, 40, 40};
   // 10 MHz clock
   always #50 pclk = ~pclk;
   dcss_master_model u_mlm (.pclk(pclk), .act_low(act_low), .req(req),
      .open_command(pin_o), .close_command(pin_c),
      .reduced_speed_command(pin_r));
   dcss_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .open_command(pin_o), .close_command(pin_c),
      .reduced_speed_command(pin_r), .can_open_req(can[2]),
      .can_close_req(can[1]), .can_reduced_req(can[0]),
      .door_at_open_pos(at_open), .door_at_closed_pos(at_closed),
      .motion_open(m_o), .motion_close(m_c), .motion_reduced(m_r),
      .speed_start(sp_s), .speed_high(sp_h), .speed_final(sp_f),
      .door_closed_relay(rly_c), .door_open_relay(rly_o),
      .auxiliary_closed_relay(aux));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the release reach the slave before the next setup
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic cfg(input logic [31:0] v, input logic al);
      act_low <= al;
      wr(dcss_pkg::CFG_OFS, v);
   endtask : cfg
   task automatic pins(input logic [2:0] r);
      req <= r;
      repeat (8) @(posedge pclk);
   endtask : pins
   task automatic mot(input logic [2:0] m, input logic [9:0] h);
      chk({29'h0, m_o, m_c, m_r}, {29'h0, m});
      chk({22'h0, sp_h}, {22'h0, h});
   endtask : mot
   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(dcss_pkg::CFG_OFS, 32'h0);
      rd(dcss_pkg::PROF_OFS, 32'h22);
      chk({30'h0, rly_c, rly_o}, 32'h3);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("done reset and refusal");
      pins(3'b101);
      mot(3'b011, 10'h028);
      cfg(32'h30, 1'b1);
      pins(3'b101);
      mot(3'b011, 10'h028);
      cfg(32'h20, 1'b0);
      pins(3'b001);
      mot(3'b000, 10'h000);
      pins(3'b101);
      mot(3'b101, 10'h032);
      pins(3'b011);
      mot(3'b011, 10'h028);
      cfg(32'h10, 1'b1);
      pins(3'b001);
      mot(3'b000, 10'h000);
      pins(3'b101);
      mot(3'b101, 10'h032);
      $display("done command modes");
      cfg(32'h20, 1'b0);
      for (int i = 0; i < 5; i++) begin
         wr(dcss_pkg::PROF_OFS, 32'(i * 17));
         pins(3'b100);
         mot(3'b100, 10'(oh[i]));
         chk({22'h0, sp_s}, 32'(os[i]));
         chk({22'h0, sp_f}, 32'(fs[i]));
         pins(3'b010);
         mot(3'b010, 10'(ch[i]));
         chk({22'h0, sp_s}, 32'(cs[i]));
         chk({22'h0, sp_f}, 32'(fs[i]));
      end
      wr(dcss_pkg::PROF_OFS, 32'h55);
      rd(dcss_pkg::PROF_OFS, 32'h44);
      $display("done profiles");
      cfg(32'h21, 1'b0);
      pins(3'b100);
      mot(3'b100, 10'h1f4);
      wr(dcss_pkg::PROF_OFS, 32'h80000044);
      rd(dcss_pkg::PROF_OFS, 32'h22);
      $display("done glass and reset trigger");
      pins(3'b000);
      at_closed <= 1'b1;
      cfg(32'h20, 1'b0);
      repeat (3) @(posedge pclk);
      chk({30'h0, rly_c, rly_o}, 32'h1);
      cfg(32'h120, 1'b0);
      repeat (3) @(posedge pclk);
      chk({30'h0, rly_c, rly_o}, 32'h3);
      cfg(32'h220, 1'b0);
      repeat (3) @(posedge pclk);
      chk({30'h0, rly_c, rly_o}, 32'h0);
      $display("done relays");
      at_closed <= 1'b0;
      wr(dcss_pkg::WEIGHT_OFS, 32'hc8);
      wr(dcss_pkg::PROF_OFS, 32'h40);
      repeat (1100) @(posedge pclk);
      apb(1'b0, dcss_pkg::STAT_OFS, 32'h0);
      chk({22'h0, q[25:16]}, 32'h13c);
      pins(3'b010);
      mot(3'b010, 10'h13c);
      $display("done energy cap");
      cfg(32'h40, 1'b0);
      pins(3'b100);
      mot(3'b000, 10'h000);
      can <= 3'b100;
      at_closed <= 1'b1;
      repeat (3) @(posedge pclk);
      mot(3'b100, 10'h12c);
      chk({29'h0, rly_c, rly_o, aux}, 32'h7);
      $display("done canopen mode");
      tally_and_finish();
   end
endmodule : dcss_top_tb_top
`default_nettype wire
